// ### hw/shc_pkg.sv
// constants and types shared by the security command handler
package shc_pkg;
   localparam logic [7:0] SOH = 8'h01;
   localparam logic [7:0] STX = 8'h02;
   localparam logic [7:0] ETX = 8'h03;
   localparam logic [7:0] CMD_ID_AUTH = 8'h9c;
   localparam logic [7:0] CMD_SEC_SET = 8'ha0;
   localparam logic [7:0] LEN_ID_AUTH = 8'h11;
   localparam logic [7:0] LEN_SEC_SET = 8'h01;
   localparam logic [7:0] LEN_SETTINGS = 8'h08;
   localparam logic [7:0] LEN_RESP = 8'h01;
   // response status codes; only the acknowledge value is fixed by the protocol
   localparam logic [7:0] ST_ACK = 8'h06;
   localparam logic [7:0] ST_NACK = 8'h15;
   localparam logic [7:0] ST_CMD_NUM = 8'h04;
   localparam logic [7:0] ST_PARAM = 8'h05;
   localparam logic [7:0] ST_CKSUM = 8'h07;
   localparam logic [7:0] ST_ID_AUTH = 8'h0e;
   localparam logic [7:0] ST_PROTECT = 8'h10;
   localparam logic [7:0] ST_ERASE = 8'h1a;
   localparam logic [7:0] ST_WRITE = 8'h1b;
   localparam logic [7:0] ST_VERIFY = 8'h1c;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] ID_FIRST = 8'h01;
   localparam logic [7:0] ID_LAST = 8'h10;
   localparam logic [3:0] ID_IDX_ONE = 4'h1;
   // data packet byte positions after the length byte
   localparam logic [7:0] POS_FLAG = 8'h00;
   localparam logic [7:0] POS_START_LO = 8'h02;
   localparam logic [7:0] POS_START_HI = 8'h03;
   localparam logic [7:0] POS_END_LO = 8'h04;
   localparam logic [7:0] POS_END_HI = 8'h05;
   // flag bits 0,3,5,6 must be one; bits 1,2,4 must never go 0 to 1
   localparam logic [7:0] FLAG_ONES_MASK = 8'h69;
   localparam logic [7:0] FLAG_PROT_MASK = 8'h16;
   localparam logic [7:0] BLOCK_HI_MASK = 8'hfc;
   localparam logic [9:0] BLOCK_ONE = 10'h001;
   localparam logic [2:0] RESP_FIRST = 3'h0;
   localparam logic [2:0] RESP_LAST = 3'h4;
   localparam logic [2:0] RESP_STEP = 3'h1;

   typedef enum logic [3:0] {
      S_WAIT_SOH,
      S_LEN,
      S_BODY,
      S_SUM,
      S_END,
      S_EVAL,
      S_SEND,
      S_WAIT_STX,
      S_FLASH,
      S_HANG
   } shc_state_e;
endpackage

// ### hw/shc_sum.sv
// running byte sum for packet checksum checking
`timescale 1ns/1ps
module shc_sum (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clr,
   input wire logic add,
   input wire logic [7:0] data,
   output logic [7:0] acc
);
   typedef struct packed {
      logic [7:0] acc;
   } shc_sum_s;

   shc_sum_s r;
   shc_sum_s next_r;

   always_comb begin
      next_r = r;
      if (clr) begin
         next_r.acc = shc_pkg::ZERO_BYTE;
      end else if (add) begin
         next_r.acc = r.acc + data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign acc = r.acc;
endmodule

// ### hw/shc_resp.sv
// sends one five byte status response packet
`timescale 1ns/1ps
module shc_resp (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic go,
   input wire logic [7:0] status,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic done
);
   typedef struct packed {
      logic active;
      logic [2:0] idx;
      logic [7:0] sts;
      logic [7:0] tx_byte;
      logic done;
   } shc_resp_s;

   shc_resp_s r;
   shc_resp_s next_r;
   logic [2:0] idx_n;
   logic [7:0] sel_byte;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      idx_n = r.idx + shc_pkg::RESP_STEP;
      // checksum is the negated sum of length and status
      case (idx_n)
         3'h1: sel_byte = shc_pkg::LEN_RESP;
         3'h2: sel_byte = r.sts;
         3'h3: sel_byte = shc_pkg::ZERO_BYTE - shc_pkg::LEN_RESP - r.sts;
         default: sel_byte = shc_pkg::ETX;
      endcase
      if (!r.active) begin
         if (go) begin
            next_r.active = 1'b1;
            next_r.idx = shc_pkg::RESP_FIRST;
            next_r.sts = status;
            next_r.tx_byte = shc_pkg::STX;
         end
      end else if (tx_ready) begin
         if (r.idx == shc_pkg::RESP_LAST) begin
            next_r.active = 1'b0;
            next_r.done = 1'b1;
         end else begin
            next_r.idx = idx_n;
            next_r.tx_byte = sel_byte;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tx_valid = r.active;
   assign tx_byte = r.tx_byte;
   assign done = r.done;
endmodule

// ### hw/shc_security_cmd.sv
// security command interpreter: id authentication and security set
`timescale 1ns/1ps
module shc_security_cmd (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic [127:0] connection_id_code,
   input wire logic [9:0] code_flash_last_block,
   input wire logic [7:0] current_flag_byte,
   output logic opt_req,
   output logic [7:0] security_flag_byte,
   output logic [9:0] window_start_field,
   output logic [9:0] window_end_field,
   input wire logic seq_done,
   input wire logic erase_fail_flag,
   input wire logic write_fail_flag,
   input wire logic verify_fail_flag,
   input wire logic sequencer_fault_flag,
   input wire logic extra_sequencer_fault_flag,
   output logic command_phase,
   output logic hung,
   output logic [7:0] response_status_byte
);
   typedef struct packed {
      shc_pkg::shc_state_e st;
      shc_pkg::shc_state_e after_send;
      logic is_data;
      logic accept_phase;
      logic hung;
      logic [7:0] len;
      logic [7:0] cnt;
      logic [7:0] cmd;
      logic id_ok;
      logic sum_ok;
      logic end_ok;
      logic [7:0] flag;
      logic [7:0] start_lo;
      logic [7:0] start_hi;
      logic [7:0] end_lo;
      logic [7:0] end_hi;
      logic resp_go;
      logic [7:0] sts;
      logic opt_req;
      logic [7:0] opt_flag;
      logic [9:0] opt_start;
      logic [9:0] opt_end;
   } shc_main_s;

   shc_main_s r;
   shc_main_s next_r;

   logic sum_clr;
   logic sum_add;
   logic [7:0] sum_acc;
   logic resp_done;
   logic [3:0] id_idx;
   logic [9:0] win_start;
   logic [9:0] win_end;
   logic bad_window;
   logic bad_flag;

   shc_sum u_sum (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clr(sum_clr),
      .add(sum_add),
      .data(rx_byte),
      .acc(sum_acc)
   );

   shc_resp u_resp (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .go(r.resp_go),
      .status(r.sts),
      .tx_ready(tx_ready),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .done(resp_done)
   );

   always_comb begin
      next_r = r;
      next_r.resp_go = 1'b0;
      next_r.opt_req = 1'b0;
      sum_clr = 1'b0;
      sum_add = 1'b0;
      id_idx = r.cnt[3:0] - shc_pkg::ID_IDX_ONE;
      win_start = {r.start_hi[1:0], r.start_lo};
      win_end = {r.end_hi[1:0], r.end_lo};
      // high bits set, reversed or out-of-flash window are all refused
      bad_window = ((r.start_hi & shc_pkg::BLOCK_HI_MASK) != shc_pkg::ZERO_BYTE)
         || ((r.end_hi & shc_pkg::BLOCK_HI_MASK) != shc_pkg::ZERO_BYTE)
         || (win_start > win_end)
         || (win_end > code_flash_last_block);
      // fixed-one bits wrong or an enable going back from 0 to 1
      bad_flag = ((r.flag & shc_pkg::FLAG_ONES_MASK) != shc_pkg::FLAG_ONES_MASK)
         || ((~current_flag_byte & r.flag & shc_pkg::FLAG_PROT_MASK)
         != shc_pkg::ZERO_BYTE);
      case (r.st)
         shc_pkg::S_WAIT_SOH: begin
            if (rx_valid && rx_byte == shc_pkg::SOH) begin
               sum_clr = 1'b1;
               next_r.is_data = 1'b0;
               next_r.cmd = shc_pkg::ZERO_BYTE;
               next_r.id_ok = 1'b1;
               next_r.st = shc_pkg::S_LEN;
            end
         end
         shc_pkg::S_WAIT_STX: begin
            // anything before the start byte is dropped
            if (rx_valid && rx_byte == shc_pkg::STX) begin
               sum_clr = 1'b1;
               next_r.is_data = 1'b1;
               next_r.st = shc_pkg::S_LEN;
            end
         end
         shc_pkg::S_LEN: begin
            if (rx_valid) begin
               sum_add = 1'b1;
               next_r.len = rx_byte;
               next_r.cnt = shc_pkg::ZERO_BYTE;
               next_r.st = (rx_byte == shc_pkg::ZERO_BYTE) ? shc_pkg::S_SUM
                  : shc_pkg::S_BODY;
            end
         end
         shc_pkg::S_BODY: begin
            if (rx_valid) begin
               sum_add = 1'b1;
               next_r.cnt = r.cnt + shc_pkg::CNT_ONE;
               if (r.cnt == r.len - shc_pkg::CNT_ONE) begin
                  next_r.st = shc_pkg::S_SUM;
               end
               if (!r.is_data) begin
                  if (r.cnt == shc_pkg::ZERO_BYTE) begin
                     next_r.cmd = rx_byte;
                  end else if (r.cnt >= shc_pkg::ID_FIRST && r.cnt <= shc_pkg::ID_LAST
                     && rx_byte != connection_id_code[8 * id_idx +: 8]) begin
                     next_r.id_ok = 1'b0;
                  end
               end else begin
                  // reserved bytes are simply not stored
                  if (r.cnt == shc_pkg::POS_FLAG) begin
                     next_r.flag = rx_byte;
                  end else if (r.cnt == shc_pkg::POS_START_LO) begin
                     next_r.start_lo = rx_byte;
                  end else if (r.cnt == shc_pkg::POS_START_HI) begin
                     next_r.start_hi = rx_byte;
                  end else if (r.cnt == shc_pkg::POS_END_LO) begin
                     next_r.end_lo = rx_byte;
                  end else if (r.cnt == shc_pkg::POS_END_HI) begin
                     next_r.end_hi = rx_byte;
                  end
               end
            end
         end
         shc_pkg::S_SUM: begin
            if (rx_valid) begin
               next_r.sum_ok = (sum_acc + rx_byte) == shc_pkg::ZERO_BYTE;
               next_r.st = shc_pkg::S_END;
            end
         end
         shc_pkg::S_END: begin
            if (rx_valid) begin
               next_r.end_ok = (rx_byte == shc_pkg::ETX);
               next_r.st = shc_pkg::S_EVAL;
            end
         end
         shc_pkg::S_EVAL: begin
            next_r.resp_go = 1'b1;
            next_r.st = shc_pkg::S_SEND;
            next_r.after_send = shc_pkg::S_WAIT_SOH;
            if (!r.end_ok) begin
               next_r.sts = shc_pkg::ST_NACK;
            end else if (!r.sum_ok) begin
               next_r.sts = shc_pkg::ST_CKSUM;
            end else if (r.is_data) begin
               if (r.len != shc_pkg::LEN_SETTINGS) begin
                  next_r.sts = shc_pkg::ST_NACK;
               end else if (bad_window) begin
                  next_r.sts = shc_pkg::ST_PARAM;
               end else if (bad_flag) begin
                  next_r.sts = shc_pkg::ST_PROTECT;
               end else begin
                  // nothing goes out until the sequencer has answered
                  next_r.resp_go = 1'b0;
                  next_r.opt_req = 1'b1;
                  next_r.opt_flag = r.flag;
                  next_r.opt_start = win_start;
                  next_r.opt_end = win_end + shc_pkg::BLOCK_ONE;
                  next_r.st = shc_pkg::S_FLASH;
               end
            end else if (r.cmd == shc_pkg::CMD_ID_AUTH) begin
               if (r.accept_phase) begin
                  next_r.sts = shc_pkg::ST_CMD_NUM;
               end else if (r.len != shc_pkg::LEN_ID_AUTH) begin
                  next_r.sts = shc_pkg::ST_NACK;
               end else if (r.id_ok) begin
                  next_r.sts = shc_pkg::ST_ACK;
                  next_r.accept_phase = 1'b1;
               end else begin
                  next_r.sts = shc_pkg::ST_ID_AUTH;
                  next_r.after_send = shc_pkg::S_HANG;
               end
            end else if (r.cmd == shc_pkg::CMD_SEC_SET) begin
               if (!r.accept_phase) begin
                  next_r.sts = shc_pkg::ST_CMD_NUM;
               end else if (r.len != shc_pkg::LEN_SEC_SET) begin
                  next_r.sts = shc_pkg::ST_NACK;
               end else begin
                  next_r.sts = shc_pkg::ST_ACK;
                  next_r.after_send = shc_pkg::S_WAIT_STX;
               end
            end else begin
               next_r.sts = shc_pkg::ST_CMD_NUM;
            end
         end
         shc_pkg::S_FLASH: begin
            if (seq_done) begin
               next_r.resp_go = 1'b1;
               next_r.st = shc_pkg::S_SEND;
               next_r.after_send = shc_pkg::S_WAIT_SOH;
               if (erase_fail_flag) begin
                  next_r.sts = shc_pkg::ST_ERASE;
               end else if (write_fail_flag) begin
                  next_r.sts = shc_pkg::ST_WRITE;
               end else if (verify_fail_flag) begin
                  next_r.sts = shc_pkg::ST_VERIFY;
               end else if (sequencer_fault_flag || extra_sequencer_fault_flag) begin
                  next_r.sts = shc_pkg::ST_PROTECT;
               end else begin
                  next_r.sts = shc_pkg::ST_ACK;
               end
            end
         end
         shc_pkg::S_SEND: begin
            // incoming bytes are ignored while the response goes out
            if (resp_done) begin
               next_r.st = r.after_send;
               next_r.hung = (r.after_send == shc_pkg::S_HANG);
            end
         end
         shc_pkg::S_HANG: begin
            // only a reset leaves this state
            next_r.st = shc_pkg::S_HANG;
         end
         default: begin
            next_r.st = shc_pkg::S_WAIT_SOH;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         r <= '0;
         r.st <= shc_pkg::S_WAIT_SOH;
         r.after_send <= shc_pkg::S_WAIT_SOH;
      end else begin
         r <= next_r;
      end
   end

   assign opt_req = r.opt_req;
   assign security_flag_byte = r.opt_flag;
   assign window_start_field = r.opt_start;
   assign window_end_field = r.opt_end;
   assign command_phase = r.accept_phase;
   assign hung = r.hung;
   assign response_status_byte = r.sts;
endmodule

// ### tb/shc_monitor.sv
// port checker for the security command handler
`timescale 1ns/1ps
module shc_monitor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic tx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic [9:0] code_flash_last_block,
   input wire logic [7:0] current_flag_byte,
   input wire logic opt_req,
   input wire logic [7:0] security_flag_byte,
   input wire logic [9:0] window_start_field,
   input wire logic [9:0] window_end_field,
   input wire logic seq_done,
   input wire logic command_phase,
   input wire logic hung
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_taken5;
      $rose(tx_valid) ##0 (tx_valid && tx_ready) [*5];
   endsequence
   sequence s_rewrite;
      opt_req ##[1:40] seq_done;
   endsequence
   AST_FRAME: assert property (s_taken5 |-> tx_byte == shc_pkg::ETX
      && $past(tx_byte, 4) == shc_pkg::STX && $past(tx_byte, 3) == shc_pkg::LEN_RESP
      && $past(tx_byte, 1) == 8'h00 - 8'h01 - $past(tx_byte, 2) ##1 !tx_valid)
      else $error("response frame malformed");
   AST_OPT_PULSE: assert property (opt_req |=> !opt_req && !tx_valid)
      else $error("rewrite request not a single pulse");
   AST_WINDOW: assert property (opt_req |->
      window_start_field <= window_end_field - 10'h001
      && window_end_field - 10'h001 <= code_flash_last_block)
      else $error("window bounds passed on unchecked");
   AST_FLAG: assert property (opt_req |->
      (security_flag_byte & shc_pkg::FLAG_ONES_MASK) == shc_pkg::FLAG_ONES_MASK
      && (security_flag_byte & ~current_flag_byte & shc_pkg::FLAG_PROT_MASK) == 8'h00)
      else $error("forbidden flag value requested");
   AST_FLASH_RESP: assert property (s_rewrite |-> ##[1:2] $rose(tx_valid))
      else $error("no response after rewrite finished");
   AST_HUNG_STAYS: assert property (hung |=> hung)
      else $error("hang released without reset");
   AST_HUNG_QUIET: assert property (hung |-> !tx_valid && !opt_req && !command_phase)
      else $error("activity while hung");
   AST_PHASE: assert property (command_phase |=> command_phase)
      else $error("command phase lost");
endmodule
bind shc_security_cmd shc_monitor u_shc_monitor (
   .sys_clk(sys_clk),
   .resetn(resetn),
   .tx_ready(tx_ready),
   .tx_valid(tx_valid),
   .tx_byte(tx_byte),
   .code_flash_last_block(code_flash_last_block),
   .current_flag_byte(current_flag_byte),
   .opt_req(opt_req),
   .security_flag_byte(security_flag_byte),
   .window_start_field(window_start_field),
   .window_end_field(window_end_field),
   .seq_done(seq_done),
   .command_phase(command_phase),
   .hung(hung)
);

// ### tb/shc_flash_model.sv
// flash sequencer stand-in holding the option area
`timescale 1ns/1ps
module shc_flash_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic opt_req,
   input wire logic [7:0] security_flag_byte,
   input wire logic [9:0] window_start_field,
   input wire logic [9:0] window_end_field,
   input wire logic [4:0] fault,
   output logic seq_done,
   output logic [4:0] fail,
   output logic [7:0] stored_flag,
   output logic [9:0] stored_end
);
   logic [3:0] wait_cnt;
   logic busy;
   // junk outside the done pulse catches early sampling
   assign fail = seq_done ? fault : ~fault;
   always @(posedge sys_clk) begin
      seq_done <= 1'b0;
      if (!resetn) begin
         busy <= 1'b0;
         wait_cnt <= 4'h0;
         stored_flag <= 8'hff;
         stored_end <= 10'h000;
      end else if (opt_req) begin
         busy <= 1'b1;
         wait_cnt <= 4'h7;
      end else if (busy) begin
         wait_cnt <= wait_cnt - 4'h1;
         if (wait_cnt == 4'h0) begin
            busy <= 1'b0;
            seq_done <= 1'b1;
            // any fault leaves the old contents in place
            if (fault == 5'h00) begin
               stored_flag <= security_flag_byte;
               stored_end <= window_end_field;
            end
         end
      end
   end
endmodule

// ### tb/tb_shc_security_cmd.sv
// self-checking bench for the security command handler
`timescale 1ns/1ps
module tb_shc_security_cmd;
   localparam logic [127:0] ID = 128'hf7f6f5f4f3f2f1f0efcdab8967452301;
   // flag, start lo/hi, end lo/hi, fault, corrupt, expected status
   localparam logic [63:0] TBL [0:12] = '{64'hed02004001000006, 64'hed50014001000005,
      64'hed02000002000005, 64'hed02044001000005, 64'hff02004001000010,
      64'hec02004001000010, 64'hed0200400101001a, 64'hed0200400102001b,
      64'hed0200400104001c, 64'hed02004001080010, 64'hed02004001100010,
      64'hed02004001000107, 64'hed02004001000215};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic tx_ready = 1'b1;
   logic [9:0] last_blk = 10'h1ff;
   logic [4:0] fault = 5'h00;
   logic tx_valid, opt_req, seq_done, command_phase, hung;
   logic [7:0] tx_byte, flag_out, stored_flag, status, fb, bb, ex, exp_flag;
   logic [9:0] start_f, end_f, stored_end;
   logic [4:0] fail;
   logic [7:0] buf_q [0:17];
   int failures = 0;
   int cmp_count = 0;
   int k;
   always #12.5 sys_clk = ~sys_clk;
   shc_security_cmd u_shc_security_cmd (.sys_clk(sys_clk), .resetn(resetn),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .connection_id_code(ID), .code_flash_last_block(last_blk),
      .current_flag_byte(stored_flag), .opt_req(opt_req), .security_flag_byte(flag_out),
      .window_start_field(start_f), .window_end_field(end_f), .seq_done(seq_done),
      .erase_fail_flag(fail[0]), .write_fail_flag(fail[1]), .verify_fail_flag(fail[2]),
      .sequencer_fault_flag(fail[3]), .extra_sequencer_fault_flag(fail[4]),
      .command_phase(command_phase), .hung(hung), .response_status_byte(status));
   shc_flash_model u_shc_flash_model (.sys_clk(sys_clk), .resetn(resetn), .opt_req(opt_req),
      .security_flag_byte(flag_out), .window_start_field(start_f), .window_end_field(end_f),
      .fault(fault), .seq_done(seq_done), .fail(fail), .stored_flag(stored_flag),
      .stored_end(stored_end));
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rst;
      resetn = 1'b0;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      @(negedge sys_clk);
   endtask
   task send(input logic [7:0] b);
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_byte = b;
      @(negedge sys_clk);
      rx_valid = 1'b0;
      rx_byte = ~b;
   endtask
   task pkt(input logic [7:0] st, input logic [7:0] len, input logic [1:0] bad);
      logic [7:0] sum;
      sum = 8'h00 - len;
      send(st);
      send(len);
      for (int i = 0; i < len; i++) begin
         send(buf_q[i]);
         sum = sum - buf_q[i];
      end
      send(sum ^ {7'h00, bad[0]});
      send(bad[1] ? 8'h04 : shc_pkg::ETX);
   endtask
   task resp(input logic [7:0] st);
      logic [7:0] exp [0:4];
      int n;
      exp = '{shc_pkg::STX, shc_pkg::LEN_RESP, st, 8'h00 - 8'h01 - st, shc_pkg::ETX};
      n = 0;
      while (tx_valid !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      for (int i = 0; i < 5; i++) begin
         chk({8'h00, tx_valid ? tx_byte : 8'hxx}, {8'h00, exp[i]});
         @(negedge sys_clk);
      end
      @(negedge sys_clk);
   endtask
   initial begin
      // tests take about 41k cycles, most of it the host pause after the id acknowledge
      repeat (60000) @(posedge sys_clk);
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      close_out;
   end
   initial begin
      rst;
      buf_q[0] = shc_pkg::CMD_SEC_SET;
      pkt(shc_pkg::SOH, 8'h01, 2'b00);
      resp(shc_pkg::ST_CMD_NUM);
      buf_q[0] = shc_pkg::CMD_ID_AUTH;
      for (int i = 0; i < 16; i++) buf_q[i + 1] = ID[8 * i +: 8];
      pkt(shc_pkg::SOH, 8'h11, 2'b10);
      resp(shc_pkg::ST_NACK);
      pkt(shc_pkg::SOH, 8'h11, 2'b01);
      resp(shc_pkg::ST_CKSUM);
      pkt(shc_pkg::SOH, 8'h10, 2'b00);
      resp(shc_pkg::ST_NACK);
      pkt(shc_pkg::SOH, 8'h11, 2'b00);
      resp(shc_pkg::ST_ACK);
      chk({15'h0, command_phase}, 16'h0001);
      // host pause of at least 1 ms after the id acknowledge
      repeat (40000) @(negedge sys_clk);
      pkt(shc_pkg::SOH, 8'h11, 2'b00);
      resp(shc_pkg::ST_CMD_NUM);
      $display("authentication tests done");
      exp_flag = 8'hff;
      for (k = 0; k < 13; k++) begin
         buf_q[0] = shc_pkg::CMD_SEC_SET;
         pkt(shc_pkg::SOH, 8'h01, 2'b00);
         resp(shc_pkg::ST_ACK);
         send(8'h55);
         send(shc_pkg::SOH);
         {buf_q[0], buf_q[2], buf_q[3], buf_q[4], buf_q[5], fb, bb, ex} = TBL[k];
         buf_q[1] = 8'ha5;
         buf_q[6] = 8'h5a;
         buf_q[7] = 8'hff;
         fault = fb[4:0];
         pkt(shc_pkg::STX, shc_pkg::LEN_SETTINGS, bb[1:0]);
         resp(ex);
         chk({8'h00, status}, {8'h00, ex});
         if (ex == shc_pkg::ST_ACK) begin
            exp_flag = buf_q[0];
            chk({6'h0, start_f}, {6'h0, buf_q[3][1:0], buf_q[2]});
            chk({6'h0, stored_end}, {6'h0, {buf_q[5][1:0], buf_q[4]} + 10'h001});
         end
         chk({8'h00, stored_flag}, {8'h00, exp_flag});
      end
      fault = 5'h00;
      $display("security set tests done");
      // reset before the next command, as after a rewrite failure
      rst;
      // settings tests overwrote the packet buffer
      buf_q[0] = shc_pkg::CMD_ID_AUTH;
      for (int i = 0; i < 16; i++) buf_q[i + 1] = ID[8 * i +: 8];
      buf_q[16] = buf_q[16] ^ 8'h01;
      pkt(shc_pkg::SOH, 8'h11, 2'b00);
      resp(shc_pkg::ST_ID_AUTH);
      pkt(shc_pkg::SOH, 8'h11, 2'b00);
      repeat (30) @(negedge sys_clk);
      chk({14'h0, tx_valid, hung}, 16'h0001);
      $display("id failure test done");
      close_out;
   end
endmodule
